/* File: logic/gst_pkg.sv */
/*
  Constants, register map and state layout of the gated sixteen-bit
  timer. Assumes a byte-wide register port addressed by the plain
  register offsets and a single 100 MHz clock.
*/
package gst_pkg;

  // Clock and instruction-clock divider
  localparam int unsigned GST_MCLK_HZ    = 100_000_000;
  localparam int unsigned GST_INSTR_DIV  = 4;
  localparam int unsigned GST_DIV_W      = 2;

  // Register offsets
  localparam int unsigned GST_ADDR_W     = 9;
  localparam logic [8:0] GST_OFS_INTERRUPT_CONTROL  = 9'h00B;
  localparam logic [8:0] GST_OFS_PERIPHERAL_FLAGS   = 9'h00C;
  localparam logic [8:0] GST_OFS_COUNT_LOW_BYTE     = 9'h00E;
  localparam logic [8:0] GST_OFS_COUNT_HIGH_BYTE    = 9'h00F;
  localparam logic [8:0] GST_OFS_TIMER_CONTROL      = 9'h010;
  localparam logic [8:0] GST_OFS_PERIPHERAL_ENABLES = 9'h08C;
  localparam logic [8:0] GST_OFS_ANALOG_SELECT      = 9'h091;
  localparam logic [8:0] GST_OFS_COMPARATOR_TWO_CFG = 9'h11B;

  // Field positions
  localparam int unsigned GST_TC_ON_BIT        = 0;
  localparam int unsigned GST_TC_CLK_SRC_BIT   = 1;
  localparam int unsigned GST_TC_SYNC_DIS_BIT  = 2;
  localparam int unsigned GST_TC_OSC_EN_BIT    = 3;
  localparam int unsigned GST_TC_PRESCALE_LSB  = 4;
  localparam int unsigned GST_TC_GATE_EN_BIT   = 6;
  localparam int unsigned GST_TC_GATE_INV_BIT  = 7;
  localparam int unsigned GST_IC_GLOBAL_BIT    = 7;
  localparam int unsigned GST_IC_PERIPH_BIT    = 6;
  localparam int unsigned GST_PF_ROLLOVER_BIT  = 0;
  localparam int unsigned GST_PE_ROLLOVER_BIT  = 0;
  localparam int unsigned GST_C2_GATE_SRC_BIT  = 1;
  localparam int unsigned GST_C2_SYNC_BIT      = 0;
  localparam int unsigned GST_C2_CMP_OUT_BIT   = 6;

  // Synchroniser lanes
  localparam int unsigned GST_PIN_COUNT = 0;
  localparam int unsigned GST_PIN_GATE  = 1;
  localparam int unsigned GST_PIN_CMP   = 2;
  localparam int unsigned GST_PIN_OSC   = 3;
  localparam int unsigned GST_PIN_N     = 4;

  // Reset values
  localparam logic [7:0]  GST_RST_TIMER_CONTROL = 8'h00;
  localparam logic [7:0]  GST_RST_ANALOG_SELECT = 8'hFF;
  localparam logic [7:0]  GST_RST_CMP_TWO_CFG   = 8'h02;
  localparam logic [15:0] GST_RST_COUNT         = 16'h0000;
  localparam logic [15:0] GST_COUNT_ALL_ONES    = 16'hFFFF;

  typedef struct packed {
    logic [GST_ADDR_W-1:0] addr;
    logic [7:0]            wdata;
    logic                  wr;
    logic                  rd;
  } gst_bus_req_type;

  typedef struct packed {
    logic [7:0]           timer_control;
    logic                 global_irq_enable;
    logic                 peripheral_irq_enable;
    logic                 rollover_irq_enable;
    logic                 rollover_flag;
    logic [7:0]           analog_select;
    logic                 gate_source_select;
    logic                 comparator_sync;
    logic [15:0]          count;
    logic [2:0]           prescale_cnt;
    logic [GST_DIV_W-1:0] div_cnt;
    logic [GST_PIN_N-1:0] sync_a;
    logic [GST_PIN_N-1:0] sync_b;
    logic                 ext_prev;
    logic                 seen_fall;
    logic                 edge_pend;
    logic                 on_prev;
    logic [7:0]           rdata;
    logic                 osc_force;
    logic                 keep_osc;
  } gst_state_type;

  localparam gst_state_type GST_STATE_RST = '{
    timer_control:         GST_RST_TIMER_CONTROL,
    analog_select:         GST_RST_ANALOG_SELECT,
    gate_source_select:    GST_RST_CMP_TWO_CFG[GST_C2_GATE_SRC_BIT],
    comparator_sync:       GST_RST_CMP_TWO_CFG[GST_C2_SYNC_BIT],
    count:                 GST_RST_COUNT,
    default:               '0
  };

endpackage : gst_pkg

/* File: logic/gst_timer.sv */
/*
  Gated sixteen-bit timer/counter with prescaler, gate selection and
  rollover flag, plus its register port. Assumes every pin input is
  asynchronous to mclk, and that the core outside acts on the irq and
  wake outputs and tells the block when it sleeps.
*/
// Chosen here: strobed register access.
`timescale 1ns/10ps

// Function
// - Count wraps all-ones to zero, setting flag
// - Request needs own, peripheral, global enables
// - Prescale divides by 1, 2, 4, 8
// - Prescaler hidden; cleared by count writes
// - Gate from pin or comparator output
// - Gate enable qualifies counting while on
// - Invert bit picks gate polarity
// - Source: pin rising edges or instruction clock
// - External input synchronised unless disabled
// - Count advances only while timer on
// - Oscillator enable honoured in permitted modes
// - Unsynchronised counting continues through sleep
// - Count byte reads always return valid
// - Oscillator pins forced input, read zero
// - Shared oscillator keeps running in sleep
// - Wake on overflow when on, enabled
// - Wake vectors only with global enable
// - Falling edge needed before first count
module gst_timer #(
  parameter int unsigned INSTR_DIV = gst_pkg::GST_INSTR_DIV
) (
  // Clock and reset
  input  wire logic                    mclk,
  input  wire logic                    nrst,
  // Register port
  input  wire gst_pkg::gst_bus_req_type bus_req,
  output logic [7:0]                   bus_rdata,
  // Pins
  input  wire logic                    count_input_pin,
  input  wire logic                    gate_pin,
  input  wire logic                    comparator_two_output,
  input  wire logic                    lp_osc_clk_pin,
  // System status
  input  wire logic                    sleep_active,
  input  wire logic                    sys_clock_lp_capable,
  input  wire logic                    sys_clock_shares_lp,
  // Core signals
  output logic                         irq_request,
  output logic                         wake_request,
  output logic                         wake_to_vector,
  output logic                         keep_osc_in_sleep,
  output logic                         osc_pin_dir_force,
  output logic                         osc_pin_port_zero
);

  localparam logic [gst_pkg::GST_DIV_W-1:0] DIV_LAST =
    (gst_pkg::GST_DIV_W)'(INSTR_DIV - 1);

  if (INSTR_DIV < 2 || INSTR_DIV > (1 << gst_pkg::GST_DIV_W)) begin : g_chk
    $error("INSTR_DIV does not fit the instruction divider");
  end

  // Last prescale state for each divide setting
  function automatic logic [2:0] prescale_last(input logic [1:0] sel);
    case (sel)
      2'h0:    prescale_last = 3'h0;
      2'h1:    prescale_last = 3'h1;
      2'h2:    prescale_last = 3'h3;
      default: prescale_last = 3'h7;
    endcase
  endfunction : prescale_last

  function automatic logic wr_hit(input gst_pkg::gst_bus_req_type req,
                                  input logic [8:0] ofs);
    wr_hit = req.wr && (req.addr == ofs);
  endfunction : wr_hit

  gst_pkg::gst_state_type s_reg;
  gst_pkg::gst_state_type s_next;

  logic       tc_on;
  logic       tc_ext;
  logic       tc_async;
  logic       tc_gate_en;
  logic       tc_gate_inv;
  logic [1:0] tc_ps;
  logic       lp_eff;
  logic       instr_en;
  logic       ext_now;
  logic       ext_rise;
  logic       ext_fall;
  logic       ext_edge;
  logic       sync_tick;
  logic       src_tick;
  logic       gate_src;
  logic       gate_true;
  logic       run;
  logic       gated;
  logic       incr;
  logic       wrap;
  logic       count_wr;
  logic       on_rise;
  logic [7:0] rd_byte;

  assign tc_on       = s_reg.timer_control[gst_pkg::GST_TC_ON_BIT];
  assign tc_ext      = s_reg.timer_control[gst_pkg::GST_TC_CLK_SRC_BIT];
  assign tc_async    = s_reg.timer_control[gst_pkg::GST_TC_SYNC_DIS_BIT];
  assign tc_gate_en  = s_reg.timer_control[gst_pkg::GST_TC_GATE_EN_BIT];
  assign tc_gate_inv = s_reg.timer_control[gst_pkg::GST_TC_GATE_INV_BIT];
  assign tc_ps       = s_reg.timer_control[gst_pkg::GST_TC_PRESCALE_LSB +: 2];

  always_comb begin
    s_next = s_reg;
    // Pins pass two flip-flops before anything looks at them
    s_next.sync_a = {lp_osc_clk_pin, comparator_two_output,
                     gate_pin, count_input_pin};
    s_next.sync_b = s_reg.sync_a;

    // Instruction clock stops in sleep along with the core
    instr_en = (s_reg.div_cnt == DIV_LAST) && !sleep_active;
    s_next.div_cnt = (s_reg.div_cnt == DIV_LAST) ?
                     '0 : s_reg.div_cnt + 1'b1;

    lp_eff = s_reg.timer_control[gst_pkg::GST_TC_OSC_EN_BIT] &&
             sys_clock_lp_capable;
    ext_now = lp_eff ? s_reg.sync_b[gst_pkg::GST_PIN_OSC] :
                       s_reg.sync_b[gst_pkg::GST_PIN_COUNT];
    s_next.ext_prev = ext_now;
    ext_rise = !s_reg.ext_prev && ext_now;
    ext_fall = s_reg.ext_prev && !ext_now;

    count_wr = wr_hit(bus_req, gst_pkg::GST_OFS_COUNT_LOW_BYTE) ||
               wr_hit(bus_req, gst_pkg::GST_OFS_COUNT_HIGH_BYTE);
    on_rise = tc_on && !s_reg.on_prev;
    s_next.on_prev = tc_on;

    // A rising edge only counts once a falling edge has been seen
    if (count_wr || on_rise) begin
      s_next.seen_fall = 1'b0;
    end else if (ext_fall) begin
      s_next.seen_fall = 1'b1;
    end
    ext_edge = ext_rise && s_reg.seen_fall;

    // Synchronised mode defers each edge to the next instruction
    // cycle; that halts it in sleep, which is the price paid for
    // a count that the compare logic can safely sample.
    sync_tick = instr_en && (s_reg.edge_pend || ext_edge);
    s_next.edge_pend = (s_reg.edge_pend || ext_edge) && !instr_en &&
                       !sleep_active;
    if (tc_ext) begin
      src_tick = tc_async ? ext_edge : sync_tick;
    end else begin
      src_tick = instr_en;
    end

    gate_src = s_reg.gate_source_select ?
               s_reg.sync_b[gst_pkg::GST_PIN_CMP] :
               s_reg.sync_b[gst_pkg::GST_PIN_GATE];
    gate_true = tc_gate_inv ? gate_src : !gate_src;
    run = tc_on && (!tc_gate_en || gate_true);
    gated = src_tick && run;

    incr = gated && (s_reg.prescale_cnt == prescale_last(tc_ps));
    if (count_wr) begin
      s_next.prescale_cnt = 3'h0;
    end else if (gated) begin
      s_next.prescale_cnt = incr ? 3'h0 : s_reg.prescale_cnt + 3'h1;
    end

    wrap = incr && (s_reg.count == gst_pkg::GST_COUNT_ALL_ONES);
    if (incr) begin
      s_next.count = s_reg.count + 16'h0001;
    end

    // Software writes; a count write beats a coincident increment in the byte it writes
    if (wr_hit(bus_req, gst_pkg::GST_OFS_COUNT_LOW_BYTE)) begin
      s_next.count[7:0] = bus_req.wdata;
    end
    if (wr_hit(bus_req, gst_pkg::GST_OFS_COUNT_HIGH_BYTE)) begin
      s_next.count[15:8] = bus_req.wdata;
    end
    if (wr_hit(bus_req, gst_pkg::GST_OFS_TIMER_CONTROL)) begin
      s_next.timer_control = bus_req.wdata;
    end
    if (wr_hit(bus_req, gst_pkg::GST_OFS_INTERRUPT_CONTROL)) begin
      s_next.global_irq_enable =
        bus_req.wdata[gst_pkg::GST_IC_GLOBAL_BIT];
      s_next.peripheral_irq_enable =
        bus_req.wdata[gst_pkg::GST_IC_PERIPH_BIT];
    end
    if (wr_hit(bus_req, gst_pkg::GST_OFS_PERIPHERAL_ENABLES)) begin
      s_next.rollover_irq_enable =
        bus_req.wdata[gst_pkg::GST_PE_ROLLOVER_BIT];
    end
    if (wr_hit(bus_req, gst_pkg::GST_OFS_ANALOG_SELECT)) begin
      s_next.analog_select = bus_req.wdata;
    end
    if (wr_hit(bus_req, gst_pkg::GST_OFS_COMPARATOR_TWO_CFG)) begin
      s_next.gate_source_select =
        bus_req.wdata[gst_pkg::GST_C2_GATE_SRC_BIT];
      s_next.comparator_sync = bus_req.wdata[gst_pkg::GST_C2_SYNC_BIT];
    end
    if (wr_hit(bus_req, gst_pkg::GST_OFS_PERIPHERAL_FLAGS)) begin
      s_next.rollover_flag = bus_req.wdata[gst_pkg::GST_PF_ROLLOVER_BIT];
    end
    // Set after the write, so a wrap in the clearing cycle survives
    if (wrap) begin
      s_next.rollover_flag = 1'b1;
    end

    // Reads come from the one-clock count, so a byte is never torn
    rd_byte = 8'h00;
    case (bus_req.addr)
      gst_pkg::GST_OFS_INTERRUPT_CONTROL: begin
        rd_byte[gst_pkg::GST_IC_GLOBAL_BIT] = s_reg.global_irq_enable;
        rd_byte[gst_pkg::GST_IC_PERIPH_BIT] = s_reg.peripheral_irq_enable;
      end
      gst_pkg::GST_OFS_PERIPHERAL_FLAGS: begin
        rd_byte[gst_pkg::GST_PF_ROLLOVER_BIT] = s_reg.rollover_flag;
      end
      gst_pkg::GST_OFS_COUNT_LOW_BYTE: begin
        rd_byte = s_reg.count[7:0];
      end
      gst_pkg::GST_OFS_COUNT_HIGH_BYTE: begin
        rd_byte = s_reg.count[15:8];
      end
      gst_pkg::GST_OFS_TIMER_CONTROL: begin
        rd_byte = s_reg.timer_control;
      end
      gst_pkg::GST_OFS_PERIPHERAL_ENABLES: begin
        rd_byte[gst_pkg::GST_PE_ROLLOVER_BIT] = s_reg.rollover_irq_enable;
      end
      gst_pkg::GST_OFS_ANALOG_SELECT: begin
        rd_byte = s_reg.analog_select;
      end
      gst_pkg::GST_OFS_COMPARATOR_TWO_CFG: begin
        rd_byte[gst_pkg::GST_C2_CMP_OUT_BIT] =
          s_reg.sync_b[gst_pkg::GST_PIN_CMP];
        rd_byte[gst_pkg::GST_C2_GATE_SRC_BIT] = s_reg.gate_source_select;
        rd_byte[gst_pkg::GST_C2_SYNC_BIT] = s_reg.comparator_sync;
      end
      default: begin
        rd_byte = 8'h00;
      end
    endcase
    s_next.rdata = bus_req.rd ? rd_byte : 8'h00;

    s_next.osc_force = lp_eff;
    s_next.keep_osc = lp_eff && sys_clock_shares_lp;
  end

  always_ff @(posedge mclk) begin
    if (!nrst) begin
      s_reg <= gst_pkg::GST_STATE_RST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign bus_rdata = s_reg.rdata;
  assign irq_request = s_reg.rollover_flag && s_reg.rollover_irq_enable &&
                       s_reg.peripheral_irq_enable &&
                       s_reg.global_irq_enable;
  // Wake does not need the global enable; it only picks the vector
  assign wake_request = s_reg.rollover_flag && s_reg.rollover_irq_enable &&
                        s_reg.peripheral_irq_enable && tc_on;
  assign wake_to_vector = wake_request && s_reg.global_irq_enable;
  assign keep_osc_in_sleep = s_reg.keep_osc;
  assign osc_pin_dir_force = s_reg.osc_force;
  assign osc_pin_port_zero = s_reg.osc_force;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!nrst);

  sequence wrap_seq;
    incr && !count_wr && s_reg.count == gst_pkg::GST_COUNT_ALL_ONES;
  endsequence

  wrap_to_zero_a: assert property (
    wrap_seq |=> s_reg.count == 16'h0000 && s_reg.rollover_flag)
    else $error("wrap did not give zero count and flag");

  irq_after_wrap_a: assert property (
    wrap_seq ##0 (s_reg.rollover_irq_enable &&
      s_reg.peripheral_irq_enable && s_reg.global_irq_enable &&
      !bus_req.wr) |=> irq_request)
    else $error("enabled rollover gave no request");

  prescale_step_a: assert property (
    gated && !count_wr && s_reg.prescale_cnt != prescale_last(tc_ps)
      |=> s_reg.count == $past(s_reg.count))
    else $error("count moved before prescale completed");

  prescale_clear_a: assert property (
    count_wr |=> s_reg.prescale_cnt == 3'h0 && !s_reg.seen_fall)
    else $error("count write left prescaler or edge arm");

  gate_block_a: assert property (
    tc_on && tc_gate_en && !gate_true && !count_wr
      |=> $stable(s_reg.count))
    else $error("count moved while gate false");

  off_hold_a: assert property (
    !tc_on && !count_wr |=> $stable(s_reg.count) [*1])
    else $error("count moved while timer off");

  sleep_hold_a: assert property (
    sleep_active && !(tc_ext && tc_async) && !count_wr
      |=> $stable(s_reg.count))
    else $error("count moved in sleep without async mode");

  wake_after_wrap_a: assert property (
    wrap_seq ##0 (tc_on && s_reg.rollover_irq_enable &&
      s_reg.peripheral_irq_enable && !bus_req.wr)
      |=> wake_request ##0 (wake_to_vector == s_reg.global_irq_enable))
    else $error("overflow wake missing or wrong vector");

  first_fall_a: assert property (
    !s_reg.seen_fall && !count_wr && !on_rise && !ext_fall ##1 ext_rise
      |-> !ext_edge)
    else $error("rising edge counted before falling edge");

  // Undivided timer mode must step on every instruction tick
  instr_step_a: assert property (
    tc_on && !tc_ext && !tc_gate_en && tc_ps == 2'h0 && instr_en &&
      s_reg.prescale_cnt == 3'h0 && !count_wr
      |=> s_reg.count == $past(s_reg.count) + 16'h0001)
    else $error("instruction tick did not advance count");

  low_byte_write_a: assert property (
    wr_hit(bus_req, gst_pkg::GST_OFS_COUNT_LOW_BYTE)
      |=> s_reg.count[7:0] == $past(bus_req.wdata))
    else $error("low count byte write lost");

  read_idle_zero_a: assert property (
    !bus_req.rd |=> bus_rdata == 8'h00)
    else $error("read data outside answer cycle");

  osc_force_a: assert property (
    $rose(lp_eff) |=> osc_pin_dir_force && osc_pin_port_zero)
    else $error("oscillator pins not forced");

endmodule : gst_timer

/* File: verification/gst_pulse_model.sv */
/*
  Pulse source standing for the external count clock and the
  low-power oscillator pin. Assumes the bench asks for a burst with a
  one-cycle go strobe and waits while busy is high.
*/
`timescale 1ns/10ps

module gst_pulse_model (
  // Clock and reset
  input  wire logic       mclk,
  input  wire logic       nrst,
  // Command
  input  wire logic       go,
  input  wire logic [7:0] npulse,
  input  wire logic       to_osc,
  output logic            busy,
  // Pins
  output logic            count_input_pin,
  output logic            lp_osc_clk_pin
);
  logic [7:0] left_reg;
  logic [2:0] ph_reg;
  logic       lvl_reg;
  logic       osc_reg;

  // A clock source always drives its pin, so idle is a firm low
  assign busy            = (left_reg != 8'h00);
  assign count_input_pin = osc_reg ? 1'b0 : lvl_reg;
  assign lp_osc_clk_pin  = osc_reg ? lvl_reg : 1'b0;

  // Four cycles low then four high per pulse; ends low
  always_ff @(posedge mclk) begin
    if (!nrst) begin
      left_reg <= 8'h00;
      ph_reg   <= 3'h0;
      lvl_reg  <= 1'b0;
      osc_reg  <= 1'b0;
    end else if (go) begin
      left_reg <= npulse;
      ph_reg   <= 3'h0;
      lvl_reg  <= 1'b0;
      osc_reg  <= to_osc;
    end else if (busy) begin
      ph_reg  <= ph_reg + 3'h1;
      lvl_reg <= (ph_reg >= 3'h3) && (ph_reg != 3'h7);
      if (ph_reg == 3'h7) begin
        left_reg <= left_reg - 8'h01;
      end
    end
  end
endmodule : gst_pulse_model

/* File: verification/gst_timer_tb_top.sv */
/*
  Self-checking bench of the gated sixteen-bit timer. Assumes the
  pulse model drives the count and oscillator pins; the bench drives
  the register port, gate inputs and system status.
*/
`timescale 1ns/10ps

module gst_timer_tb_top;
  localparam int unsigned DIV = 4;
  localparam logic [8:0] A_IC = gst_pkg::GST_OFS_INTERRUPT_CONTROL;
  localparam logic [8:0] A_PF = gst_pkg::GST_OFS_PERIPHERAL_FLAGS;
  localparam logic [8:0] A_LO = gst_pkg::GST_OFS_COUNT_LOW_BYTE;
  localparam logic [8:0] A_HI = gst_pkg::GST_OFS_COUNT_HIGH_BYTE;
  localparam logic [8:0] A_TC = gst_pkg::GST_OFS_TIMER_CONTROL;
  localparam logic [8:0] A_PE = gst_pkg::GST_OFS_PERIPHERAL_ENABLES;
  localparam logic [8:0] A_AS = gst_pkg::GST_OFS_ANALOG_SELECT;
  localparam logic [8:0] A_C2 = gst_pkg::GST_OFS_COMPARATOR_TWO_CFG;
  localparam logic [16:0] RST_TAB [9] = '{{A_IC, 8'h00}, {A_PF, 8'h00},
    {A_LO, 8'h00}, {A_HI, 8'h00}, {A_TC, 8'h00}, {A_PE, 8'h00},
    {A_AS, 8'hFF}, {A_C2, 8'h02}, {9'h00D, 8'h00}};
  // Bits: on, gate enable, invert, source, pin, comparator, counts
  localparam logic [6:0] GATE_TAB [8] = '{7'h75, 7'h70, 7'h61, 7'h7B,
    7'h7C, 7'h69, 7'h51, 7'h00};

  logic                     mclk = 1'b0;
  logic                     nrst = 1'b0;
  gst_pkg::gst_bus_req_type req = '0;
  logic [7:0]               bus_rdata;
  logic                     gate_pin = 1'b0;
  logic                     comparator_two_output = 1'b0;
  logic                     sleep_active = 1'b0;
  logic                     sys_clock_lp_capable = 1'b0;
  logic                     sys_clock_shares_lp = 1'b0;
  logic                     irq_request, wake_request, wake_to_vector;
  logic                     keep_osc, dir_force, port_zero;
  logic                     count_input_pin, lp_osc_clk_pin, busy;
  logic                     go = 1'b0;
  logic                     to_osc = 1'b0;
  logic [7:0]               npulse = 8'h00;
  logic [8:0]               note_q [$];
  logic [8:0]               note;
  logic                     rd_q = 1'b0;
  logic [7:0]               last_rd;
  int                       bad_count = 0;
  int                       cmp_count = 0;
  int                       cyc = 0;

  always #5 mclk = ~mclk;

  gst_timer #(.INSTR_DIV(DIV)) i_gst_timer (
    .mclk(mclk), .nrst(nrst), .bus_req(req), .bus_rdata(bus_rdata),
    .count_input_pin(count_input_pin), .gate_pin(gate_pin),
    .comparator_two_output(comparator_two_output),
    .lp_osc_clk_pin(lp_osc_clk_pin), .sleep_active(sleep_active),
    .sys_clock_lp_capable(sys_clock_lp_capable),
    .sys_clock_shares_lp(sys_clock_shares_lp),
    .irq_request(irq_request), .wake_request(wake_request),
    .wake_to_vector(wake_to_vector), .keep_osc_in_sleep(keep_osc),
    .osc_pin_dir_force(dir_force), .osc_pin_port_zero(port_zero));

  gst_pulse_model i_gst_pulse_model (
    .mclk(mclk), .nrst(nrst), .go(go), .npulse(npulse), .to_osc(to_osc),
    .busy(busy), .count_input_pin(count_input_pin),
    .lp_osc_clk_pin(lp_osc_clk_pin));

  task automatic fail(input string msg);
    bad_count++;
    $display("[FAIL] %0t %s", $time, msg);
  endtask : fail

  task automatic end_sim;
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : end_sim

  task automatic chk(input logic [7:0] got, input logic [7:0] exp,
                     input string msg);
    cmp_count++;
    if (got !== exp) fail(msg);
  endtask : chk

  task automatic wr(input logic [8:0] a, input logic [7:0] d);
    @(posedge mclk);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    req.wr <= 1'b0;
  endtask : wr

  task automatic rd(input logic [8:0] a, input logic [7:0] e,
                    input logic c);
    @(posedge mclk);
    req.addr <= a;
    req.rd <= 1'b1;
    note_q.push_back({c, e});
    @(posedge mclk);
    req.rd <= 1'b0;
  endtask : rd

  task automatic cnt(input logic [15:0] e);
    rd(A_LO, e[7:0], 1'b1);
    rd(A_HI, e[15:8], 1'b1);
  endtask : cnt

  // No count edges arrive while the two bytes are written
  task automatic clr;
    wr(A_LO, 8'h00);
    wr(A_HI, 8'h00);
  endtask : clr

  task automatic pulses(input logic [7:0] n, input logic o);
    int w;
    @(posedge mclk);
    go <= 1'b1;
    npulse <= n;
    to_osc <= o;
    @(posedge mclk);
    go <= 1'b0;
    w = 0;
    do begin
      @(posedge mclk);
      w++;
    end while (busy && w < 3000);
    if (w >= 3000) fail("pulse model hung");
    // Room for synchroniser and deferred increments to land
    repeat (6) @(posedge mclk);
  endtask : pulses

  // Read data stand only in the cycle after the strobe
  always @(posedge mclk) begin
    rd_q <= req.rd;
    if (rd_q) begin
      note = note_q.pop_front();
      last_rd <= bus_rdata;
      if (note[8]) chk(bus_rdata, note[7:0], "read data mismatch");
    end else if (nrst) begin
      chk(bus_rdata, 8'h00, "read data outside answer cycle");
    end
  end

  always @(posedge mclk) begin
    cyc++;
    if (cyc == 60000) begin
      fail("timeout");
      end_sim();
    end
  end

  initial begin
    logic [15:0] r;
    logic [7:0]  v1;
    logic [6:0]  g;
    int          n;
    void'($urandom(30639));
    repeat (10) @(posedge mclk);
    nrst <= 1'b1;
    foreach (RST_TAB[i]) rd(RST_TAB[i][16:8], RST_TAB[i][7:0], 1'b1);
    comparator_two_output <= 1'b1;
    repeat (4) @(posedge mclk);
    rd(A_C2, 8'h42, 1'b1);
    comparator_two_output <= 1'b0;
    repeat (4) begin
      r = 16'($urandom);
      wr(A_LO, r[7:0]);
      wr(A_HI, r[15:8]);
      cnt(r);
    end
    $display("test registers done");
    clr();
    wr(A_TC, 8'h01);
    rd(A_LO, 8'h00, 1'b0);
    @(posedge mclk);
    #1 v1 = last_rd;
    repeat (37) @(posedge mclk);
    rd(A_LO, 8'h00, 1'b0);
    @(posedge mclk);
    #1 chk(last_rd - v1, 8'(40 / DIV), "instruction clock rate");
    for (int ps = 0; ps < 4; ps++) begin
      n = 9 + ($urandom % 16);
      wr(A_TC, 8'h07 | 8'(ps << 4));
      clr();
      pulses(8'(n), 1'b0);
      cnt(16'((n - 1) >> ps));
    end
    wr(A_TC, 8'h37);
    clr();
    pulses(8'd6, 1'b0);
    wr(A_LO, 8'h00);
    pulses(8'd5, 1'b0);
    cnt(16'h0000);
    pulses(8'd4, 1'b0);
    cnt(16'h0001);
    $display("test prescaler done");
    foreach (GATE_TAB[i]) begin
      g = GATE_TAB[i];
      gate_pin <= g[2];
      comparator_two_output <= g[1];
      wr(A_C2, {6'h00, g[3], 1'b0});
      wr(A_TC, {g[4], g[5], 5'b00011, g[6]});
      clr();
      pulses(8'd5, 1'b0);
      cnt(g[0] ? 16'h0004 : 16'h0000);
    end
    gate_pin <= 1'b0;
    comparator_two_output <= 1'b0;
    $display("test gate done");
    for (int k = 0; k < 3; k++) begin
      sleep_active <= (k > 0);
      wr(A_TC, (k == 2) ? 8'h07 : 8'h03);
      clr();
      pulses(8'd5, 1'b0);
      cnt((k == 1) ? 16'h0000 : 16'h0004);
    end
    sleep_active <= 1'b0;
    $display("test sleep done");
    wr(A_PE, 8'h01);
    wr(A_IC, 8'hC0);
    @(posedge mclk);
    #1 chk({5'h00, irq_request, wake_request, wake_to_vector}, 8'h00,
           "request without flag");
    wr(A_LO, 8'hFF);
    wr(A_HI, 8'hFF);
    pulses(8'd2, 1'b0);
    cnt(16'h0000);
    rd(A_PF, 8'h01, 1'b1);
    #1 chk({5'h00, irq_request, wake_request, wake_to_vector}, 8'h07,
           "requests after wrap");
    wr(A_IC, 8'h40);
    @(posedge mclk);
    #1 chk({5'h00, irq_request, wake_request, wake_to_vector}, 8'h02,
           "global enable clear");
    wr(A_TC, 8'h06);
    @(posedge mclk);
    #1 chk({7'h00, wake_request}, 8'h00, "wake while off");
    wr(A_PF, 8'h00);
    rd(A_PF, 8'h00, 1'b1);
    $display("test rollover done");
    sys_clock_lp_capable <= 1'b1;
    sys_clock_shares_lp <= 1'b1;
    wr(A_TC, 8'h08);
    repeat (20) @(posedge mclk);
    wr(A_TC, 8'h0F);
    clr();
    pulses(8'd5, 1'b1);
    cnt(16'h0004);
    #1 chk({5'h00, keep_osc, dir_force, port_zero}, 8'h07,
           "oscillator pin and sleep control");
    sys_clock_shares_lp <= 1'b0;
    wr(A_TC, 8'h07);
    repeat (3) @(posedge mclk);
    #1 chk({5'h00, keep_osc, dir_force, port_zero}, 8'h00,
           "oscillator released");
    sys_clock_lp_capable <= 1'b0;
    wr(A_TC, 8'h0F);
    clr();
    pulses(8'd5, 1'b1);
    cnt(16'h0000);
    $display("test oscillator done");
    end_sim();
  end
endmodule : gst_timer_tb_top
